// ### hdl/pfcc_pkg.sv
// ==========================================
// loop filter and calibration wait constants
package pfcc_pkg;
	// register offsets on the management port
	localparam logic [7:0] PFCC_ADDR_CAP1 = 8'h25;
	localparam logic [7:0] PFCC_ADDR_RES3 = 8'h26;
	localparam logic [7:0] PFCC_ADDR_CAP3 = 8'h27;
	localparam logic [7:0] PFCC_ADDR_CALW = 8'h2a;
	localparam logic [7:0] PFCC_ADDR_CSUM = 8'h2f;
	// field positions
	localparam int PFCC_CAP1_MSB = 2;
	localparam int PFCC_RES3_MSB = 6;
	localparam int PFCC_CAP3_MSB = 2;
	localparam int PFCC_CLSD_MSB = 3;
	localparam int PFCC_CLSD_LSB = 2;
	localparam int PFCC_OSC_MSB  = 1;
	// reset values
	localparam logic [2:0] PFCC_CAP1_RST = 3'h2;
	localparam logic [6:0] PFCC_RES3_RST = 7'h00;
	localparam logic [2:0] PFCC_CAP3_RST = 3'h7;
	localparam logic [1:0] PFCC_CLSD_RST = 2'h2;
	localparam logic [1:0] PFCC_OSC_RST  = 2'h1;
	localparam logic [7:0] PFCC_CSUM_RST = 8'h00;
	// memory image: words 0..4 hold cap1, res3, cap3, calw, checksum
	localparam logic [2:0] PFCC_NVM_LAST = 3'h4;
	// clock rate and settle waits
	localparam int unsigned PFCC_CLK_MHZ   = 200;
	localparam int unsigned PFCC_OSC_US0   = 20;
	localparam int unsigned PFCC_OSC_US1   = 400;
	localparam int unsigned PFCC_OSC_US2   = 4000;
	localparam int unsigned PFCC_OSC_US3   = 10000;
	localparam int unsigned PFCC_CLSD_US0  = 150;
	localparam int unsigned PFCC_CLSD_US1  = 300;
	localparam int unsigned PFCC_CLSD_US2  = 500;
	localparam int unsigned PFCC_CLSD_US3  = 2000;
	localparam int unsigned PFCC_OSC_CYC0  = PFCC_OSC_US0 * PFCC_CLK_MHZ;
	localparam int unsigned PFCC_OSC_CYC1  = PFCC_OSC_US1 * PFCC_CLK_MHZ;
	localparam int unsigned PFCC_OSC_CYC2  = PFCC_OSC_US2 * PFCC_CLK_MHZ;
	localparam int unsigned PFCC_OSC_CYC3  = PFCC_OSC_US3 * PFCC_CLK_MHZ;
	localparam int unsigned PFCC_CLSD_CYC0 = PFCC_CLSD_US0 * PFCC_CLK_MHZ;
	localparam int unsigned PFCC_CLSD_CYC1 = PFCC_CLSD_US1 * PFCC_CLK_MHZ;
	localparam int unsigned PFCC_CLSD_CYC2 = PFCC_CLSD_US2 * PFCC_CLK_MHZ;
	localparam int unsigned PFCC_CLSD_CYC3 = PFCC_CLSD_US3 * PFCC_CLK_MHZ;
endpackage

// ### hdl/pfcc_wait_timer.sv
`timescale 1ns/1ps
// ==========================================
// one-shot wait timer: done_q pulses len+1 cycles after start
module pfcc_wait_timer #(
	parameter int W = 22
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         start,   // load and run
	input  wire logic [W-1:0] len,     // wait in cycles, at least 1
	output logic              done_q   // one-cycle pulse at expiry
);
	logic [W-1:0] cnt_q, cnt_d;        // cycles left
	logic         run_q, run_d;        // counting
	logic         done_d;

	// next state of the counter
	always_comb begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		done_d = 1'b0;
		if (start) begin
			cnt_d = len - W'(1);
			run_d = 1'b1;
		end else if (run_q) begin
			if (cnt_q == '0) begin
				run_d  = 1'b0;
				done_d = 1'b1;
			end else begin
				cnt_d = cnt_q - W'(1);
			end
		end
	end

	// registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			run_q  <= run_d;
			done_q <= done_d;
		end
	end
endmodule // pfcc_wait_timer

// ### hdl/pfcc_regs.sv
`timescale 1ns/1ps
// How it works
// - first loop capacitor code, bits 2:0, reset 2
// - third loop resistor code, bits 6:0, reset 0
// - third loop capacitor code, bits 2:0, reset 7
// - closed-loop settle code bits 3:2, reset 2
// - oscillator settle code bits 1:0, reset 1
// - read-only stored checksum byte, writes ignored
// - memory copied into registers after reset, on command
// - checksum mismatch during load sets flag
module pfcc_regs #(
	parameter int unsigned OSC_CYC [4]  = '{pfcc_pkg::PFCC_OSC_CYC0, pfcc_pkg::PFCC_OSC_CYC1,
		pfcc_pkg::PFCC_OSC_CYC2, pfcc_pkg::PFCC_OSC_CYC3},
	parameter int unsigned CLSD_CYC [4] = '{pfcc_pkg::PFCC_CLSD_CYC0, pfcc_pkg::PFCC_CLSD_CYC1,
		pfcc_pkg::PFCC_CLSD_CYC2, pfcc_pkg::PFCC_CLSD_CYC3},
	parameter int TW = 22
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,                    // register offset
	input  wire logic       reg_wr_en,                   // write strobe
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd_en,                   // read strobe
	output logic      [7:0] reg_rdata_q,                 // data one cycle after read
	input  wire logic       mem_load_cmd,                // memory_to_register_load pulse
	output logic            nvm_rd_en_q,                 // memory word request
	output logic      [2:0] nvm_rd_addr_q,
	input  wire logic [7:0] nvm_rd_data,                 // valid cycle after request
	input  wire logic       cal_start,                   // calibration start pulse
	output logic      [2:0] first_loop_capacitor_code_q,
	output logic      [6:0] third_loop_resistor_code_q,
	output logic      [2:0] third_loop_capacitor_code_q,
	output logic      [1:0] closed_loop_settle_wait_q,
	output logic      [1:0] oscillator_settle_wait_q,
	output logic      [7:0] stored_checksum_byte_q,
	output logic            checksum_mismatch_flag_q,
	output logic            load_busy_q,                 // memory copy running
	output logic            cal_busy_q,
	output logic            cal_done_q                   // calibration complete pulse
);
	typedef enum logic [1:0] {LD_IDLE, LD_REQ, LD_WAIT, LD_CAP} pfcc_ld_e;
	typedef enum logic [1:0] {CAL_IDLE, CAL_OSC, CAL_CLSD} pfcc_cal_e;

	// ==========================================
	// register file and memory copy
	pfcc_ld_e   ld_q, ld_d;          // copy sequencer
	logic [2:0] idx_d;               // memory word index
	logic       pend_q, pend_d;      // load requested, reset sets it
	logic [7:0] sum_q, sum_d;        // xor of loaded config bytes
	logic [2:0] c1_d, c3_d;
	logic [6:0] r3_d;
	logic [1:0] clsd_d, osc_d;
	logic [7:0] csum_d, rdata_d;
	logic       flag_d, rd_en_d, busy_d;
	logic       wr_ok;               // software write accepted

	assign wr_ok = reg_wr_en && (ld_q == LD_IDLE);

	// next values of fields, sequencer and read data
	always_comb begin
		ld_d    = ld_q;
		idx_d   = nvm_rd_addr_q;
		pend_d  = pend_q | mem_load_cmd;
		sum_d   = sum_q;
		c1_d    = first_loop_capacitor_code_q;
		r3_d    = third_loop_resistor_code_q;
		c3_d    = third_loop_capacitor_code_q;
		clsd_d  = closed_loop_settle_wait_q;
		osc_d   = oscillator_settle_wait_q;
		csum_d  = stored_checksum_byte_q;
		flag_d  = checksum_mismatch_flag_q;
		rd_en_d = 1'b0;
		rdata_d = 8'h00;
		// software writes, reserved bits dropped
		if (wr_ok) begin
			if (reg_addr == pfcc_pkg::PFCC_ADDR_CAP1) begin
				c1_d = reg_wdata[pfcc_pkg::PFCC_CAP1_MSB:0];
			end else if (reg_addr == pfcc_pkg::PFCC_ADDR_RES3) begin
				r3_d = reg_wdata[pfcc_pkg::PFCC_RES3_MSB:0];
			end else if (reg_addr == pfcc_pkg::PFCC_ADDR_CAP3) begin
				c3_d = reg_wdata[pfcc_pkg::PFCC_CAP3_MSB:0];
			end else if (reg_addr == pfcc_pkg::PFCC_ADDR_CALW) begin
				clsd_d = reg_wdata[pfcc_pkg::PFCC_CLSD_MSB:pfcc_pkg::PFCC_CLSD_LSB];
				osc_d  = reg_wdata[pfcc_pkg::PFCC_OSC_MSB:0];
			end
			// checksum offset: write has no effect
		end
		// reads return zero while a copy runs or for unmapped offsets
		if (reg_rd_en && ld_q == LD_IDLE) begin
			if (reg_addr == pfcc_pkg::PFCC_ADDR_CAP1) begin
				rdata_d = {5'h00, first_loop_capacitor_code_q};
			end else if (reg_addr == pfcc_pkg::PFCC_ADDR_RES3) begin
				rdata_d = {1'b0, third_loop_resistor_code_q};
			end else if (reg_addr == pfcc_pkg::PFCC_ADDR_CAP3) begin
				rdata_d = {5'h00, third_loop_capacitor_code_q};
			end else if (reg_addr == pfcc_pkg::PFCC_ADDR_CALW) begin
				rdata_d = {4'h0, closed_loop_settle_wait_q, oscillator_settle_wait_q};
			end else if (reg_addr == pfcc_pkg::PFCC_ADDR_CSUM) begin
				rdata_d = stored_checksum_byte_q;
			end
		end
		// copy sequencer: request, wait, capture, for words 0..4
		case (ld_q)
			LD_IDLE: begin
				if (pend_q) begin
					pend_d = mem_load_cmd;
					idx_d  = 3'h0;
					sum_d  = 8'h00;
					flag_d = 1'b0;
					ld_d   = LD_REQ;
				end
			end
			LD_REQ: begin
				rd_en_d = 1'b1;
				ld_d    = LD_WAIT;
			end
			LD_WAIT: begin
				ld_d = LD_CAP;
			end
			LD_CAP: begin
				case (nvm_rd_addr_q)
					3'h0: c1_d = nvm_rd_data[pfcc_pkg::PFCC_CAP1_MSB:0];
					3'h1: r3_d = nvm_rd_data[pfcc_pkg::PFCC_RES3_MSB:0];
					3'h2: c3_d = nvm_rd_data[pfcc_pkg::PFCC_CAP3_MSB:0];
					3'h3: begin
						clsd_d = nvm_rd_data[pfcc_pkg::PFCC_CLSD_MSB:pfcc_pkg::PFCC_CLSD_LSB];
						osc_d  = nvm_rd_data[pfcc_pkg::PFCC_OSC_MSB:0];
					end
					default: csum_d = nvm_rd_data;
				endcase
				if (nvm_rd_addr_q == pfcc_pkg::PFCC_NVM_LAST) begin
					flag_d = (sum_q != nvm_rd_data);
					ld_d   = LD_IDLE;
				end else begin
					sum_d = sum_q ^ nvm_rd_data;
					idx_d = nvm_rd_addr_q + 3'h1;
					ld_d  = LD_REQ;
				end
			end
			default: ld_d = LD_IDLE;
		endcase
		busy_d = (ld_d != LD_IDLE);
	end

	// registers of the file and sequencer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ld_q                        <= LD_IDLE;
			pend_q                      <= 1'b1;
			sum_q                       <= 8'h00;
			nvm_rd_en_q                 <= 1'b0;
			nvm_rd_addr_q               <= 3'h0;
			first_loop_capacitor_code_q <= pfcc_pkg::PFCC_CAP1_RST;
			third_loop_resistor_code_q  <= pfcc_pkg::PFCC_RES3_RST;
			third_loop_capacitor_code_q <= pfcc_pkg::PFCC_CAP3_RST;
			closed_loop_settle_wait_q   <= pfcc_pkg::PFCC_CLSD_RST;
			oscillator_settle_wait_q    <= pfcc_pkg::PFCC_OSC_RST;
			stored_checksum_byte_q      <= pfcc_pkg::PFCC_CSUM_RST;
			checksum_mismatch_flag_q    <= 1'b0;
			reg_rdata_q                 <= 8'h00;
			load_busy_q                 <= 1'b0;
		end else begin
			ld_q                        <= ld_d;
			pend_q                      <= pend_d;
			sum_q                       <= sum_d;
			nvm_rd_en_q                 <= rd_en_d;
			nvm_rd_addr_q               <= idx_d;
			first_loop_capacitor_code_q <= c1_d;
			third_loop_resistor_code_q  <= r3_d;
			third_loop_capacitor_code_q <= c3_d;
			closed_loop_settle_wait_q   <= clsd_d;
			oscillator_settle_wait_q    <= osc_d;
			stored_checksum_byte_q      <= csum_d;
			checksum_mismatch_flag_q    <= flag_d;
			reg_rdata_q                 <= rdata_d;
			load_busy_q                 <= busy_d;
		end
	end

	// ==========================================
	// calibration settle waits
	pfcc_cal_e    cal_q, cal_d;
	logic         tmr_start, tmr_done, done_d, cbusy_d;
	logic [TW-1:0] tmr_len;
	logic [1:0]   cosc_q, cosc_d, cclsd_q, cclsd_d; // codes latched at start

	// oscillator wait first, then closed-loop wait
	always_comb begin
		cal_d     = cal_q;
		cosc_d    = cosc_q;
		cclsd_d   = cclsd_q;
		tmr_start = 1'b0;
		tmr_len   = TW'(OSC_CYC[oscillator_settle_wait_q]);
		done_d    = 1'b0;
		case (cal_q)
			CAL_IDLE: begin
				if (cal_start) begin
					cosc_d    = oscillator_settle_wait_q;
					cclsd_d   = closed_loop_settle_wait_q;
					tmr_start = 1'b1;
					cal_d     = CAL_OSC;
				end
			end
			CAL_OSC: begin
				tmr_len = TW'(CLSD_CYC[cclsd_q]);
				if (tmr_done) begin
					tmr_start = 1'b1;
					cal_d     = CAL_CLSD;
				end
			end
			CAL_CLSD: begin
				if (tmr_done) begin
					done_d = 1'b1;
					cal_d  = CAL_IDLE;
				end
			end
			default: cal_d = CAL_IDLE;
		endcase
		cbusy_d = (cal_d != CAL_IDLE);
	end

	// calibration registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cal_q      <= CAL_IDLE;
			cosc_q     <= 2'h0;
			cclsd_q    <= 2'h0;
			cal_busy_q <= 1'b0;
			cal_done_q <= 1'b0;
		end else begin
			cal_q      <= cal_d;
			cosc_q     <= cosc_d;
			cclsd_q    <= cclsd_d;
			cal_busy_q <= cbusy_d;
			cal_done_q <= done_d;
		end
	end

	pfcc_wait_timer #(.W(TW)) u_tmr (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.start  (tmr_start),
		.len    (tmr_len),
		.done_q (tmr_done)
	);

	// ==========================================
	// checks
	int unsigned cal_cnt_q;  // cycles since calibration start
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cal_cnt_q <= 0;
		end else if (cal_q == CAL_IDLE && cal_start) begin
			cal_cnt_q <= 1;
		end else if (cal_busy_q) begin
			cal_cnt_q <= cal_cnt_q + 1;
		end
	end
	wire idle_wr = reg_wr_en && !load_busy_q && ld_q == LD_IDLE;

	property p_cap1_wr;
		@(posedge mclk) disable iff (!rst_n)
		idle_wr && reg_addr == pfcc_pkg::PFCC_ADDR_CAP1 && !pend_q
		|=> first_loop_capacitor_code_q == $past(reg_wdata[2:0]);
	endproperty
	a_cap1_wr: assert property (p_cap1_wr) else $error("cap1 write lost");
	property p_res3_rd;
		@(posedge mclk) disable iff (!rst_n)
		reg_rd_en && !load_busy_q && ld_q == LD_IDLE && reg_addr == pfcc_pkg::PFCC_ADDR_RES3
		|=> reg_rdata_q == {1'b0, $past(third_loop_resistor_code_q)};
	endproperty
	a_res3_rd: assert property (p_res3_rd) else $error("res3 readback wrong");
	property p_cap3_wr;
		@(posedge mclk) disable iff (!rst_n)
		idle_wr && reg_addr == pfcc_pkg::PFCC_ADDR_CAP3 && !pend_q
		|=> third_loop_capacitor_code_q == $past(reg_wdata[2:0]);
	endproperty
	a_cap3_wr: assert property (p_cap3_wr) else $error("cap3 write lost");
	// readback of the third capacitor code keeps reserved bits at zero
	property p_cap3_rd;
		@(posedge mclk) disable iff (!rst_n)
		reg_rd_en && ld_q == LD_IDLE && reg_addr == pfcc_pkg::PFCC_ADDR_CAP3
		|=> reg_rdata_q == {5'h00, $past(third_loop_capacitor_code_q)};
	endproperty
	a_cap3_rd: assert property (p_cap3_rd) else $error("cap3 readback wrong");
	property p_clsd_wr;
		@(posedge mclk) disable iff (!rst_n)
		idle_wr && reg_addr == pfcc_pkg::PFCC_ADDR_CALW && !pend_q
		|=> closed_loop_settle_wait_q == $past(reg_wdata[3:2]);
	endproperty
	a_clsd_wr: assert property (p_clsd_wr) else $error("closed wait write lost");
	property p_osc_wr;
		@(posedge mclk) disable iff (!rst_n)
		idle_wr && reg_addr == pfcc_pkg::PFCC_ADDR_CALW && !pend_q
		|=> oscillator_settle_wait_q == $past(reg_wdata[1:0]);
	endproperty
	a_osc_wr: assert property (p_osc_wr) else $error("osc wait write lost");
	property p_csum_ro;
		@(posedge mclk) disable iff (!rst_n)
		ld_q == LD_IDLE && !pend_q |=> $stable(stored_checksum_byte_q);
	endproperty
	a_csum_ro: assert property (p_csum_ro) else $error("checksum byte changed");
	property p_load;
		@(posedge mclk) disable iff (!rst_n)
		mem_load_cmd ##1 ld_q == LD_IDLE |=> load_busy_q ##14 load_busy_q ##1 !load_busy_q;
	endproperty
	a_load: assert property (p_load) else $error("memory copy not run");
	property p_flag;
		@(posedge mclk) disable iff (!rst_n)
		ld_q == LD_CAP && nvm_rd_addr_q == pfcc_pkg::PFCC_NVM_LAST
		|=> checksum_mismatch_flag_q == ($past(sum_q) != $past(nvm_rd_data)) && !load_busy_q;
	endproperty
	a_flag: assert property (p_flag) else $error("mismatch flag wrong");
	property p_cal;
		@(posedge mclk) disable iff (!rst_n)
		cal_done_q |-> cal_cnt_q == OSC_CYC[cosc_q] + CLSD_CYC[cclsd_q] + 3;
	endproperty
	a_cal: assert property (p_cal) else $error("calibration wait length wrong");

	c_load: cover property (@(posedge mclk) disable iff (!rst_n) $fell(load_busy_q));
	c_flag: cover property (@(posedge mclk) disable iff (!rst_n) $rose(checksum_mismatch_flag_q));
	c_cal:  cover property (@(posedge mclk) disable iff (!rst_n) cal_done_q);
endmodule // pfcc_regs

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	// ==========================================
	// ports, counters and memory image
	logic       mclk;
	logic       rst_n;
	logic [7:0] reg_addr;
	logic       reg_wr_en;
	logic [7:0] reg_wdata;
	logic       reg_rd_en;
	logic [7:0] reg_rdata_q;
	logic       mem_load_cmd;
	logic       nvm_rd_en_q;
	logic [2:0] nvm_rd_addr_q;
	logic [7:0] nvm_rd_data;
	logic       cal_start;
	logic [2:0] cap1_q;
	logic [6:0] res3_q;
	logic [2:0] cap3_q;
	logic [1:0] clsd_q;
	logic [1:0] osc_q;
	logic [7:0] csum_q;
	logic       flag_q;
	logic       load_busy_q;
	logic       cal_busy_q;
	logic       cal_done_q;
	integer     num_errors;                 // mismatches seen
	integer     checks_done;                // comparisons made
	logic [7:0] mem [5];                    // words served to the copy sequencer
	// short settle waits keep the run brief
	localparam int unsigned OSC  [4] = '{4, 8, 12, 16};
	localparam int unsigned CLSD [4] = '{3, 5, 7, 9};

	// ==========================================
	// clock and design
	always #2.5 mclk = ~mclk;

	pfcc_regs #(.OSC_CYC(OSC), .CLSD_CYC(CLSD)) i_pfcc_regs (
		.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata_q(reg_rdata_q),
		.mem_load_cmd(mem_load_cmd), .nvm_rd_en_q(nvm_rd_en_q), .nvm_rd_addr_q(nvm_rd_addr_q),
		.nvm_rd_data(nvm_rd_data), .cal_start(cal_start),
		.first_loop_capacitor_code_q(cap1_q), .third_loop_resistor_code_q(res3_q),
		.third_loop_capacitor_code_q(cap3_q), .closed_loop_settle_wait_q(clsd_q),
		.oscillator_settle_wait_q(osc_q), .stored_checksum_byte_q(csum_q),
		.checksum_mismatch_flag_q(flag_q), .load_busy_q(load_busy_q),
		.cal_busy_q(cal_busy_q), .cal_done_q(cal_done_q)
	);

	// memory answers one cycle after a request, toggles garbage otherwise
	always @(posedge mclk) begin
		if (nvm_rd_en_q)
			nvm_rd_data <= mem[nvm_rd_addr_q];
		else
			nvm_rd_data <= ~nvm_rd_data;
	end

	// ==========================================
	// access tasks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge mclk);
		reg_wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge mclk);
		reg_rd_en <= 1'b0;
		#1;
		chk($sformatf("read %h", a), exp, reg_rdata_q);
	endtask

	// waits for a copy to start and finish, bounded
	task automatic wait_load();
		int n;
		n = 0;
		while (load_busy_q !== 1'b1 && n < 10) begin
			@(posedge mclk);
			#1;
			n++;
		end
		while (load_busy_q === 1'b1 && n < 60) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("copy finished", 8'h00, {7'h0, load_busy_q});
	endtask

	task automatic load(input bit probe);
		@(posedge mclk);
		mem_load_cmd <= 1'b1;
		@(posedge mclk);
		mem_load_cmd <= 1'b0;
		if (probe)
			rd(8'h25, 8'h00);               // refused while copying
		wait_load();
	endtask

	// counts cycles from the start pulse to the done pulse
	task automatic cal(input int o, input int c, input bit poke);
		int n;
		wr(8'h2a, {4'h0, c[1:0], o[1:0]});
		@(posedge mclk);
		cal_start <= 1'b1;
		n = 0;
		while (n < 100) begin
			@(posedge mclk);
			n++;
			cal_start <= (poke && n == 2);  // a second start while busy is ignored
			#1;
			if (n == 1)
				chk("cal busy", 8'h01, {7'h0, cal_busy_q});
			if (cal_done_q === 1'b1)
				break;
		end
		chk("cal wait", 8'(OSC[o] + CLSD[c] + 3), 8'(n));
		chk("cal idle", 8'h00, {7'h0, cal_busy_q});
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================
	// watchdog
	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		conclude();
	end

	// ==========================================
	// test sequence
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wdata = 8'h00;
		reg_rd_en = 1'b0;
		mem_load_cmd = 1'b0;
		nvm_rd_data = 8'h00;
		cal_start = 1'b0;
		num_errors = 0;
		checks_done = 0;
		mem = '{8'h02, 8'h00, 8'h07, 8'h09, 8'h0c};
		repeat (4) @(posedge mclk);
		chk("cap1 in reset", 8'h02, {5'h0, cap1_q});
		chk("res3 in reset", 8'h00, {1'h0, res3_q});
		chk("cap3 in reset", 8'h07, {5'h0, cap3_q});
		chk("clsd in reset", 8'h02, {6'h0, clsd_q});
		chk("osc in reset", 8'h01, {6'h0, osc_q});
		chk("csum in reset", 8'h00, csum_q);
		rst_n <= 1'b1;
		wait_load();
		// values after the reset copy
		rd(8'h25, 8'h02);
		rd(8'h26, 8'h00);
		rd(8'h27, 8'h07);
		rd(8'h2a, 8'h09);
		rd(8'h2f, 8'h0c);
		chk("flag", 8'h00, {7'h0, flag_q});
		$display("test reset values done");
		// writes, reserved bits, read-only and unmapped places
		wr(8'h25, 8'hff);
		rd(8'h25, 8'h07);
		wr(8'h26, 8'hff);
		rd(8'h26, 8'h7f);
		wr(8'h27, 8'hfa);
		rd(8'h27, 8'h02);
		wr(8'h2a, 8'hff);
		rd(8'h2a, 8'h0f);
		chk("clsd field", 8'h03, {6'h0, clsd_q});
		chk("osc field", 8'h03, {6'h0, osc_q});
		wr(8'h2f, 8'h55);
		rd(8'h2f, 8'h0c);
		wr(8'h30, 8'haa);
		rd(8'h30, 8'h00);
		$display("test register access done");
		// every code of both settle waits
		for (int i = 0; i < 4; i++) begin
			cal(3 - i, i, i == 0);
		end
		wr(8'h2a, 8'h09);
		rd(8'h2a, 8'h09);
		$display("test calibration done");
		// copy with a bad checksum, then a good one
		mem = '{8'h05, 8'h11, 8'h03, 8'h0e, 8'h00};
		load(1'b1);
		rd(8'h25, 8'h05);
		rd(8'h26, 8'h11);
		rd(8'h27, 8'h03);
		rd(8'h2a, 8'h0e);
		rd(8'h2f, 8'h00);
		chk("flag", 8'h01, {7'h0, flag_q});
		mem[4] = 8'h05 ^ 8'h11 ^ 8'h03 ^ 8'h0e;
		load(1'b0);
		chk("flag", 8'h00, {7'h0, flag_q});
		rd(8'h2f, 8'h19);
		$display("test memory copy done");
		conclude();
	end
endmodule // testbench
